/* File: hw/ramp_defs.vh */
// Register map, field positions, reset values and timing constants of the control list and power ramp block.
`ifndef RAMP_DEFS_VH
`define RAMP_DEFS_VH
// -----------------------------------------------------------------------------
// Register byte offsets.
// -----------------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_LENGTH 8'h04
`define REG_RAMP 8'h08
`define REG_DELAYS 8'h0C
`define REG_ATTEN 8'h10
`define REG_SRATE 8'h14
`define REG_CURSOR 8'h18
`define REG_ENTRY 8'h1C
`define REG_PRESET 8'h20
`define REG_STATUS 8'h24
`define REG_POS 8'h28
// -----------------------------------------------------------------------------
// Control register fields.
// -----------------------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_RAMP_ON 1
`define CTRL_INTERNAL 2
`define CTRL_COSINE 3
`define CTRL_MARK_LIST 4
`define CTRL_SECOND_PATH 5
`define CTRL_RESET 32'h0000_0014
// -----------------------------------------------------------------------------
// List geometry and limits.
// -----------------------------------------------------------------------------
`define LIST_DEPTH 16
`define LIST_IDX_W 4
`define POS_W 16
`define LENGTH_RESET 16'h0040
`define RAMP_TIME_RESET 8'h04
`define SRATE_MAX_KHZ 32'h0000_1388
`define ERR_RATE_BIT 0
// -----------------------------------------------------------------------------
// Preset codes.
// -----------------------------------------------------------------------------
`define PRESET_ALL_UP 3'h0
`define PRESET_ALL_DOWN 3'h1
`define PRESET_RISE 3'h2
`define PRESET_FALL 3'h3
`define PRESET_RISE_FALL 3'h4
`define PRESET_FALL_RISE 3'h5
`endif

/* File: hw/control_list_power_ramp.v */
// Control list playback and power envelope shaping with a classic Wishbone register slave.
// Contract
// R1 - Playback indexes from zero to range length.
// R2 - Playback wraps over the range length.
// R3 - Shortening range discards entries beyond it.
// R4 - Same-level entries kept, produce no change.
// R5 - Entry holds position and target level.
// R6 - Presets: all high, all low, centre edge.
// R7 - Two-edge presets symmetric about the centre.
// R8 - Cursor beyond range extends the range.
// R9 - Marker or control follows list when selected.
// R10 - Above 5 MHz ramping off, error raised.
// R11 - Internal source takes gate, attenuation from list.
// R12 - Internal source drives gate, attenuation pins.
// R13 - External party drives ramp pin when external.
// R14 - Second path attenuation uses selectable user pin.
// R15 - Edge shape linear or cosine.
// R16 - One ramp time for rise and fall.
// R17 - Signed rise offset shifts envelope start.
// R18 - Signed fall offset shifts envelope end.
// R19 - Attenuation reduces level by programmed amount.
// R20 - Outputs hold last transition level.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`default_nettype none
`include "ramp_defs.vh"
module control_list_power_ramp (
   input wire clock,
   input wire resetn,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire symbol_tick,
   input wire ext_gate_in,
   input wire ext_atten_a_in,
   input wire [3:0] user_pins_in,
   output reg [3:0] user_pins_out,
   output reg [3:0] user_pins_oe_n,
   output reg gate_pin_out,
   output reg atten_pin_out,
   output reg list_sourced_marker,
   output reg [7:0] envelope,
   output reg atten_active
);
   // -----------------------------------------------------------------------------
   // Registers and list storage.
   // -----------------------------------------------------------------------------
   reg [31:0] ctrl;
   reg [15:0] list_length;
   reg [7:0] ramp_time;
   reg [7:0] rise_off;
   reg [7:0] fall_off;
   reg [7:0] atten_db;
   reg [31:0] srate_khz;
   reg [15:0] cursor;
   reg [1:0] user_sel;
   reg [`POS_W-1:0] ent_pos [0:`LIST_DEPTH-1];
   reg ent_lvl [0:`LIST_DEPTH-1];
   reg [`LIST_DEPTH-1:0] ent_valid;
   reg rate_err;
   reg [15:0] play_pos;
   reg list_level;
   reg gate_q;
   reg [15:0] env_cnt;
   reg [7:0] ramp_cnt;
   reg env_on;
   reg env_rising;
   reg [8:0] shift_cnt;
   integer i;
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr = bus_req & wb_we_i;
   wire rate_ok = srate_khz <= `SRATE_MAX_KHZ;
   wire ramp_enable = ctrl[`CTRL_RAMP_ON] & rate_ok;
   wire internal_src = ctrl[`CTRL_INTERNAL];
   // Second path attenuation comes from the chosen user pin when external.
   wire ext_atten = ctrl[`CTRL_SECOND_PATH] ? user_pins_in[user_sel] : ext_atten_a_in; // R14 R13
   wire gate_src = internal_src ? list_level : ext_gate_in; // R11 R13
   wire atten_src = internal_src ? list_level : ext_atten; // R11
   wire [15:0] centre = {1'b0, list_length[15:1]};
   wire [15:0] quarter = {2'b00, list_length[15:2]};

   // Merges byte lanes of a write into an old register value.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] val;
      input [3:0] sel;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               merge[b*8 +: 8] = val[b*8 +: 8];
            end
         end
      end
   endfunction

   // Cosine-like edge from a linear fraction: smoothstep 3x^2 - 2x^3.
   function [7:0] shape;
      input [7:0] x;
      input cosine;
      reg [23:0] x3;
      reg [15:0] x2;
      reg [25:0] lin3;
      reg [25:0] cub2;
      reg [25:0] diff;
      begin
         x2 = x * x;
         x3 = x2 * x;
         lin3 = ({10'h000, x2} * 26'h0000003) >> 8;
         cub2 = ({2'h0, x3} * 26'h0000002) >> 16;
         diff = lin3 - cub2;
         if (cosine) begin
            // The full-scale end point reaches 256, so it is held at the top code.
            shape = diff[8] ? 8'hFF : diff[7:0];
         end else begin
            shape = x;
         end
      end
   endfunction

   // -----------------------------------------------------------------------------
   // Wishbone slave, list editing and presets.
   // -----------------------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl <= `CTRL_RESET;
         list_length <= `LENGTH_RESET;
         ramp_time <= `RAMP_TIME_RESET;
         rise_off <= 8'h00;
         fall_off <= 8'h00;
         atten_db <= 8'h00;
         srate_khz <= 32'h0000_0000;
         cursor <= 16'h0000;
         user_sel <= 2'h0;
         ent_valid <= {`LIST_DEPTH{1'b0}};
         rate_err <= 1'b0;
         for (i = 0; i < `LIST_DEPTH; i = i + 1) begin
            ent_pos[i] <= 16'h0000;
            ent_lvl[i] <= 1'b0;
         end
      end else begin
         wb_ack_o <= bus_req;
         if (ctrl[`CTRL_RAMP_ON] && !rate_ok) begin
            ctrl[`CTRL_RAMP_ON] <= 1'b0; // R10
            rate_err <= 1'b1; // R10
         end
         if (bus_wr) begin
            if (wb_adr_i == `REG_CTRL) begin
               ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
               user_sel <= wb_dat_i[9:8];
            end else if (wb_adr_i == `REG_LENGTH) begin
               list_length <= wb_dat_i[15:0];
               for (i = 0; i < `LIST_DEPTH; i = i + 1) begin
                  if (ent_pos[i] >= wb_dat_i[15:0]) begin
                     ent_valid[i] <= 1'b0; // R3
                  end
               end
            end else if (wb_adr_i == `REG_RAMP) begin
               ramp_time <= wb_dat_i[7:0]; // R16
            end else if (wb_adr_i == `REG_DELAYS) begin
               rise_off <= wb_dat_i[7:0];
               fall_off <= wb_dat_i[15:8];
            end else if (wb_adr_i == `REG_ATTEN) begin
               atten_db <= wb_dat_i[7:0];
            end else if (wb_adr_i == `REG_SRATE) begin
               srate_khz <= wb_dat_i;
            end else if (wb_adr_i == `REG_CURSOR) begin
               cursor <= wb_dat_i[15:0];
               if (wb_dat_i[15:0] >= list_length) begin
                  list_length <= wb_dat_i[15:0] + 16'h0001; // R8
               end
            end else if (wb_adr_i == `REG_ENTRY) begin
               // Word: [31:28] slot, [24] delete, [16] level, [15:0] position.
               ent_pos[wb_dat_i[31:28]] <= wb_dat_i[15:0]; // R5
               ent_lvl[wb_dat_i[31:28]] <= wb_dat_i[16]; // R5 R4
               ent_valid[wb_dat_i[31:28]] <= ~wb_dat_i[24] & (wb_dat_i[15:0] < list_length);
            end else if (wb_adr_i == `REG_PRESET) begin
               ent_valid <= {`LIST_DEPTH{1'b0}};
               ent_pos[0] <= 16'h0000;
               ent_valid[0] <= 1'b1;
               ent_valid[1] <= 1'b1;
               if (wb_dat_i[2:0] == `PRESET_ALL_UP) begin
                  ent_lvl[0] <= 1'b1; // R6
                  ent_valid[1] <= 1'b0;
               end else if (wb_dat_i[2:0] == `PRESET_ALL_DOWN) begin
                  ent_lvl[0] <= 1'b0; // R6
                  ent_valid[1] <= 1'b0;
               end else if (wb_dat_i[2:0] == `PRESET_RISE || wb_dat_i[2:0] == `PRESET_FALL) begin
                  ent_lvl[0] <= wb_dat_i[0];
                  ent_pos[1] <= centre; // R6
                  ent_lvl[1] <= ~wb_dat_i[0];
               end else begin
                  ent_lvl[0] <= wb_dat_i[0];
                  ent_pos[1] <= centre - quarter; // R7
                  ent_lvl[1] <= ~wb_dat_i[0];
                  ent_pos[2] <= centre + quarter; // R7
                  ent_lvl[2] <= wb_dat_i[0];
                  ent_valid[2] <= 1'b1;
               end
            end else if (wb_adr_i == `REG_STATUS) begin
               rate_err <= rate_err & ~wb_dat_i[`ERR_RATE_BIT];
            end
         end
         if (bus_req && !wb_we_i) begin
            if (wb_adr_i == `REG_CTRL) begin
               wb_dat_o <= {22'h0, user_sel, ctrl[7:0]};
            end else if (wb_adr_i == `REG_LENGTH) begin
               wb_dat_o <= {16'h0, list_length};
            end else if (wb_adr_i == `REG_RAMP) begin
               wb_dat_o <= {24'h0, ramp_time};
            end else if (wb_adr_i == `REG_DELAYS) begin
               wb_dat_o <= {16'h0, fall_off, rise_off};
            end else if (wb_adr_i == `REG_ATTEN) begin
               wb_dat_o <= {24'h0, atten_db};
            end else if (wb_adr_i == `REG_SRATE) begin
               wb_dat_o <= srate_khz;
            end else if (wb_adr_i == `REG_CURSOR) begin
               wb_dat_o <= {16'h0, cursor};
            end else if (wb_adr_i == `REG_ENTRY) begin
               wb_dat_o <= {16'h0, ent_valid};
            end else if (wb_adr_i == `REG_STATUS) begin
               wb_dat_o <= {24'h0, env_on, atten_active, list_level, 4'h0, rate_err};
            end else if (wb_adr_i == `REG_POS) begin
               wb_dat_o <= {16'h0, play_pos};
            end else begin
               wb_dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Playback: level of the latest valid entry at or before the position.
   // -----------------------------------------------------------------------------
   reg next_level;
   reg hit;
   reg [15:0] best;
   reg [15:0] next_pos;
   // The level is looked up at the position that playback moves to, so level and position agree.
   always @* begin
      next_level = list_level;
      hit = 1'b0;
      best = 16'h0000;
      next_pos = play_pos + 16'h0001;
      if (next_pos >= list_length) begin
         next_pos = 16'h0000; // R2
      end
      for (i = 0; i < `LIST_DEPTH; i = i + 1) begin
         if (ent_valid[i] && ent_pos[i] <= next_pos && (!hit || ent_pos[i] >= best)) begin
            hit = 1'b1;
            best = ent_pos[i];
            next_level = ent_lvl[i]; // R20 R4
         end
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         play_pos <= 16'h0000;
         list_level <= 1'b0;
      end else if (!ctrl[`CTRL_RUN]) begin
         play_pos <= 16'h0000; // R1
      end else if (symbol_tick) begin
         list_level <= next_level;
         play_pos <= next_pos; // R1 R2
      end
   end

   // -----------------------------------------------------------------------------
   // Envelope: offsets, ramp counter, shape and attenuation.
   // -----------------------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gate_q <= 1'b0;
         env_on <= 1'b0;
         env_rising <= 1'b0;
         ramp_cnt <= 8'h00;
         shift_cnt <= 9'h000;
         env_cnt <= 16'h0000;
         envelope <= 8'h00;
         atten_active <= 1'b0;
         gate_pin_out <= 1'b0;
         atten_pin_out <= 1'b0;
         list_sourced_marker <= 1'b0;
         user_pins_out <= 4'h0;
         user_pins_oe_n <= 4'hF;
      end else begin
         list_sourced_marker <= ctrl[`CTRL_MARK_LIST] & list_level; // R9
         gate_pin_out <= internal_src & list_level; // R12
         atten_pin_out <= internal_src & list_level; // R12
         user_pins_oe_n <= 4'hF;
         user_pins_out <= 4'h0;
         if (internal_src && ctrl[`CTRL_SECOND_PATH]) begin
            user_pins_oe_n[user_sel] <= 1'b0; // R14
            user_pins_out[user_sel] <= list_level; // R14
         end
         atten_active <= ramp_enable & atten_src;
         if (!ramp_enable) begin
            env_on <= 1'b0;
            shift_cnt <= 9'h000;
            envelope <= 8'hFF;
         end else if (symbol_tick) begin
            gate_q <= gate_src;
            if (gate_src != gate_q) begin
               // Offset: positive rise delays start, positive fall delays end.
               shift_cnt <= gate_src ? {1'b0, rise_off} : {1'b0, fall_off}; // R17 R18
               env_rising <= gate_src;
               // Negative offset advances the edge by starting it early into the ramp.
               if ((gate_src ? rise_off[7] : fall_off[7]) || (gate_src ? rise_off : fall_off) == 8'h00) begin
                  shift_cnt <= 9'h000;
                  env_on <= 1'b1;
                  ramp_cnt <= gate_src ? (8'h00 - rise_off) : (8'h00 - fall_off); // R17 R18
               end
            end else if (shift_cnt != 9'h000) begin
               shift_cnt <= shift_cnt - 9'h001;
               if (shift_cnt == 9'h001) begin
                  env_on <= 1'b1;
                  ramp_cnt <= 8'h00;
               end
            end else if (env_on) begin
               if (ramp_cnt + 8'h01 >= ramp_time) begin
                  env_on <= 1'b0; // R16
               end
               ramp_cnt <= ramp_cnt + 8'h01;
            end
            env_cnt <= (ramp_time == 8'h00) ? 16'h00FF : ({8'h00, ramp_cnt} * 16'h00FF) / {8'h00, ramp_time};
            if (env_on) begin
               envelope <= shape(env_rising ? env_cnt[7:0] : (8'hFF - env_cnt[7:0]), ctrl[`CTRL_COSINE]) // R15
                  >> (atten_src ? atten_db[2:0] : 3'h0); // R19
            end else begin
               envelope <= (env_rising ? 8'hFF : 8'h00) >> (atten_src ? atten_db[2:0] : 3'h0); // R19
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/ramp_checker_sva.sv */
// Port assertions for the control list and power ramp block.
`default_nettype none
module ramp_checker (
   input wire logic clock,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic symbol_tick,
   input wire logic [3:0] user_pins_out,
   input wire logic gate_pin_out,
   input wire logic atten_pin_out,
   input wire logic list_sourced_marker
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] idle;
   // Counts quiet cycles since the last symbol or access, as list-driven pins move only soon after one.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         idle <= 3'h0;
      else
         idle <= (symbol_tick || wb_cyc_i) ? 3'h0 : idle + {2'h0, idle != 3'h7};
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence req_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_on_request_a: assert property (req_taken |=> wb_ack_o) else $error("no ack");
   ack_one_cycle_a: assert property (wb_ack_o |-> ack_pulse) else $error("long ack");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   rdata_with_ack_a: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("data moved");
   gate_hold_a: assert property ($changed(gate_pin_out) |-> idle < 3'h4) else $error("gate moved");
   atten_hold_a: assert property ($changed(atten_pin_out) |-> idle < 3'h4) else $error("atten moved");
   marker_hold_a: assert property ($changed(list_sourced_marker) |-> idle < 3'h4) else $error("marker moved");
   user_hold_a: assert property ($changed(user_pins_out) |-> idle < 3'h4) else $error("user pin moved");
endmodule
`default_nettype wire

/* File: verif/aux_pins_model.sv */
// Far-side model of the auxiliary pins and the level path.
`default_nettype none
module aux_pins_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] user_pins_out,
   input wire logic [3:0] user_pins_oe_n,
   output logic ext_gate_in,
   output logic ext_atten_a_in,
   output logic [3:0] user_pins_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] pattern;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         pattern <= 5'h00;
      else
         pattern <= pattern + 5'h01;
   end
   assign ext_gate_in = pattern[3];
   assign ext_atten_a_in = pattern[4];
   // A released user pin carries a changing level, never a stale copy.
   assign user_pins_in = (user_pins_out & ~user_pins_oe_n) | (pattern[3:0] & user_pins_oe_n);
endmodule
`default_nettype wire

/* File: verif/control_list_power_ramp_bench.sv */
// Self-checking bench for the control list and power ramp block.
`default_nettype none
`include "ramp_defs.vh"
module control_list_power_ramp_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'h0, resetn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, tick = 1'h0;
   logic [7:0] adr = 8'h00, env;
   logic [3:0] sel = 4'h0, upo, uoe, upi;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, egate, eatt, gpin, apin, mark, aact;
   logic [15:0] fix [4] = '{16'hFFFF, 16'h0000, 16'hFF00, 16'h00FF};
   int n_fail = 0, n_tests = 0;
   control_list_power_ramp dut_u (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .symbol_tick(tick), .ext_gate_in(egate), .ext_atten_a_in(eatt), .user_pins_in(upi),
      .user_pins_out(upo), .user_pins_oe_n(uoe), .gate_pin_out(gpin), .atten_pin_out(apin),
      .list_sourced_marker(mark), .envelope(env), .atten_active(aact));
   aux_pins_model far_u (.clock(clock), .resetn(resetn), .user_pins_out(upo), .user_pins_oe_n(uoe),
      .ext_gate_in(egate), .ext_atten_a_in(eatt), .user_pins_in(upi));
   initial forever #2 clock = ~clock;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hF};
      do begin
         @(negedge clock);
         k++;
      end while (ack !== 1'h1 && k < 40);
      if (ack !== 1'h1)
         check(ack, 1'h1);
      q = rdat;
      @(posedge clock);
      {cyc, stb} <= 2'h0;
   endtask
   task step(output logic lvl, output logic [15:0] pos);
      @(posedge clock);
      tick <= 1'h1;
      @(posedge clock);
      tick <= 1'h0;
      wb(`REG_POS, 1'h0, 32'h0);
      pos = q[15:0];
      wb(`REG_STATUS, 1'h0, 32'h0);
      lvl = q[5];
   endtask
   task t_regs;
      wb(`REG_CTRL, 1'h0, 32'h0);
      check(q, `CTRL_RESET);
      wb(8'h3C, 1'h0, 32'h0);
      check(q, 32'h0);
      wb(`REG_CURSOR, 1'h1, 32'h9);
      wb(`REG_LENGTH, 1'h0, 32'h0);
      check(q, {16'h0, `LENGTH_RESET});
      wb(`REG_CURSOR, 1'h1, 32'h40);
      wb(`REG_LENGTH, 1'h0, 32'h0);
      check(q, 32'h41);
   endtask
   task t_playback;
      logic lvl;
      logic [15:0] pos;
      wb(`REG_CTRL, 1'h1, 32'h14);
      for (int s = 0; s < 16; s++)
         wb(`REG_ENTRY, 1'h1, {4'(s), 28'h1000000});
      wb(`REG_LENGTH, 1'h1, 32'h8);
      wb(`REG_ENTRY, 1'h1, 32'h0001_0002);
      wb(`REG_ENTRY, 1'h1, 32'h1001_0004);
      wb(`REG_ENTRY, 1'h1, 32'h2000_0005);
      wb(`REG_ENTRY, 1'h0, 32'h0);
      check(q, 32'h7);
      wb(`REG_CTRL, 1'h1, 32'h15);
      for (int k = 1; k <= 10; k++) begin
         step(lvl, pos);
         check(pos, 32'(k % 8));
         check({lvl, gpin, apin, mark}, {4{k % 8 >= 2 && k % 8 < 5}});
      end
      wb(`REG_CTRL, 1'h1, 32'h1);
      step(lvl, pos);
      check({lvl, gpin, apin, mark}, 4'h8);
      wb(`REG_LENGTH, 1'h1, 32'h5);
      wb(`REG_ENTRY, 1'h0, 32'h0);
      check(q, 32'h3);
   endtask
   task t_presets;
      logic lvl;
      logic [15:0] pos, pat, rev;
      for (int c = 0; c < 6; c++) begin
         pat = 'x;
         wb(`REG_CTRL, 1'h1, 32'h14);
         wb(`REG_LENGTH, 1'h1, 32'h10);
         wb(`REG_PRESET, 1'h1, 32'(c));
         wb(`REG_CTRL, 1'h1, 32'h15);
         for (int k = 0; k < 16; k++) begin
            step(lvl, pos);
            pat[pos[3:0]] = lvl;
         end
         rev = {<<{pat}};
         if (c < 4)
            check(pat, fix[c]);
         else
            check({pat[0], pat[8], pat ^ rev}, {c == 5, c == 4, 16'h0});
      end
   endtask
   task t_rate;
      wb(`REG_CTRL, 1'h1, 32'h16);
      wb(`REG_SRATE, 1'h1, `SRATE_MAX_KHZ);
      wb(`REG_CTRL, 1'h0, 32'h0);
      check(q[1], 1'h1);
      wb(`REG_SRATE, 1'h1, `SRATE_MAX_KHZ + 32'h1);
      wb(`REG_CTRL, 1'h0, 32'h0);
      check(q[1], 1'h0);
      wb(`REG_STATUS, 1'h0, 32'h0);
      check(q[0], 1'h1);
      check(env, 8'hFF);
   endtask
   task t_ramp;
      logic lvl;
      logic [15:0] pos;
      wb(`REG_CTRL, 1'h1, 32'h224);
      wb(`REG_CTRL, 1'h0, 32'h0);
      check(uoe, 4'hB);
      wb(`REG_SRATE, 1'h1, 32'h1);
      wb(`REG_PRESET, 1'h1, 32'h0);
      wb(`REG_ATTEN, 1'h1, 32'h1);
      wb(`REG_CTRL, 1'h1, 32'h17);
      repeat (10)
         step(lvl, pos);
      check(env, 8'h7F);
      check(aact, 1'h1);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      check(uoe, 4'hF);
      resetn <= 1'h1;
      t_regs;
      t_playback;
      t_presets;
      t_rate;
      t_ramp;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_sim;
   end
endmodule
bind control_list_power_ramp ramp_checker chk_u (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .symbol_tick(symbol_tick),
   .user_pins_out(user_pins_out), .gate_pin_out(gate_pin_out), .atten_pin_out(atten_pin_out),
   .list_sourced_marker(list_sourced_marker));
`default_nettype wire
